/* File: src/bce_params.svh */
// bce_params.svh: named constants of the blit command engine
`ifndef BCE_PARAMS_SVH
`define BCE_PARAMS_SVH
// ============================================================
// packet fields
`define BCE_F_CLIENT 31:29
`define BCE_F_OP 28:22
`define BCE_F_LEN 7:0
`define BCE_B_ALPHA 21
`define BCE_B_RGB 20
`define BCE_B_DIR 30
`define BCE_B_CLIP 30
`define BCE_B_SOLID 31
`define BCE_B_MTRANSP 28
`define BCE_F_DEPTH 25:24
`define BCE_F_ROP 23:16
`define BCE_F_HI 31:16
`define BCE_F_LO 15:0
`define BCE_F_HSEED 14:12
`define BCE_F_VSEED 10:8
`define BCE_F_CLIPV 14:0
// ============================================================
// client, opcodes and dword length fields
`define BCE_CLIENT_2D 3'h2
`define BCE_OP_SETUP 7'h01
`define BCE_OP_MSETUP 7'h11
`define BCE_OP_CLIP 7'h03
`define BCE_OP_FILL 7'h40
`define BCE_OP_LCOPY 7'h43
`define BCE_OP_PIXEL 7'h24
`define BCE_OP_SCAN 7'h25
`define BCE_OP_XYCOPY 7'h53
`define BCE_LEN_SETUP 8'h06
`define BCE_LEN_MSETUP 8'h07
`define BCE_LEN_CLIP 8'h01
`define BCE_LEN_FILL 8'h03
`define BCE_LEN_LCOPY 8'h04
`define BCE_LEN_PIXEL 8'h00
`define BCE_LEN_SCAN 8'h01
`define BCE_LEN_XYCOPY 8'h06
`define BCE_LEN_BIAS 9'h002
`define BCE_PKT_MAX 9'h009
// ============================================================
// pixel, raster operation and pattern constants
`define BCE_SH_8 2'h0
`define BCE_SH_16 2'h1
`define BCE_SH_32 2'h2
`define BCE_DEPTH_8 2'h0
`define BCE_DEPTH_32 2'h3
`define BCE_ROP_PAT 8'hf0
`define BCE_ROP_DMASK 8'h55
`define BCE_PAT_ROW_SH 3
// ============================================================
// context slots: setup control, colours, destination base, pattern, clip, extras
`define BCE_C_CTRL 0
`define BCE_C_BG 1
`define BCE_C_FG 2
`define BCE_C_PAT 3
`define BCE_C_DBASE 4
`define BCE_C_MLO 5
`define BCE_C_MHI 6
`define BCE_C_CTL 7
`define BCE_C_CBR 8
`define BCE_C_EXT 9
`define BCE_X_RGB 0
`define BCE_X_ALPHA 1
`define BCE_X_MONO 2
// ============================================================
// apb map and reset values
`define BCE_A_CTRL 12'h000
`define BCE_A_STAT 12'h004
`define BCE_A_CTX0 12'h010
`define BCE_A_CTXN 12'h034
`define BCE_S_BAD 0
`define BCE_S_BUSY 1
`define BCE_S_RCLR 2
`define BCE_RST_EN 1'b1
`endif

/* File: src/bce_pkg.sv */
// bce_pkg.sv: types of the blit command engine
package bce_pkg;
	// engine sequencer states
	typedef enum logic [3:0] {S_IDLE, S_DEC, S_CLIP, S_PIX, S_RDP, S_RDS, S_RDD, S_WR,
		S_STEP} bce_state_t;
	// command stream dword
	typedef struct packed {
		logic        valid; // dword present
		logic [31:0] data;  // packet dword
	} bce_cmd_t;
	// memory request, held until ack
	typedef struct packed {
		logic        valid; // request pending
		logic        write; // 1 write, 0 read
		logic        tex;   // 1 texture cache, 0 render cache
		logic [31:0] addr;  // dword aligned byte address
		logic [31:0] wdata; // lane aligned write data
		logic [3:0]  be;    // byte enables
	} bce_mem_req_t;
	// memory answer
	typedef struct packed {
		logic        ack;   // one-cycle completion
		logic [31:0] data;  // read data
	} bce_mem_rsp_t;
	// apb answer
	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} bce_apb_rsp_t;
	// whole engine state
	typedef struct packed {
		bce_state_t         st;
		logic [8:0][31:0]   pkt;
		logic [8:0]         cnt, tot;
		logic [9:0][31:0]   ctx;
		logic               en, bad, busy, rdy;
		logic [15:0]        rej;
		logic [6:0]         op;
		logic               alpha, rgb, clip, xy, scan, solid, transp;
		logic               use_src, use_dst, xback, yback;
		logic [7:0]         raster_operation;
		logic [1:0]         shift;
		logic signed [15:0] dpitch, spitch;
		logic [31:0]        dbase, sbase, pat, src, dst;
		logic signed [16:0] x, y, xs, xe, ys, ye, ox, oy;
		logic [2:0]         hs, vs;
		bce_mem_req_t       mem;
		bce_apb_rsp_t       apb;
	} bce_st_t;
endpackage : bce_pkg

/* File: src/bce_engine.sv */
// bce_engine.sv: blit command engine, packet decode, clipping and pixel sequencing
// Summary of operation
// - pixels of 8, 16, 32 bits, naturally aligned
// - setup commands load state used by coordinate commands
// - setup state is context, saved and restored
// - colour via render cache, patterns via texture
// - opcode field selects which control bits matter
// - fill is client 02h, opcode 40h, length 03h
// - fill raster-combines colour, width bytes by height
// - 32-bit writes: bit21 alpha, bit20 colour bytes
// - depth field 25:24 selects 8/565/1555/32
// - linear fill and copy: untiled, never clipped
// - linear copy is opcode 43h, length 04h
// - copy bit 30 walks right to left
// - source and destination pitches are signed
// - clip edges top-left inclusive; reject before access
// - negative source start shifts destination, then reject
// - address is base plus y*pitch plus x*bpp
// - same base, source x lower: walk right-left
// - same base, source y lower: walk bottom-up
// - clip words: top high, left low, 15 bits
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "bce_params.svh"
module bce_engine (
	input  wire logic                  CLK,       // core clock, 25 MHz
	input  wire logic                  SYS_RST,   // synchronous reset, active high
	input  wire bce_pkg::bce_cmd_t     CMD_IN,    // command dword with valid
	output logic                       CMD_READY, // dword taken when valid and ready
	output bce_pkg::bce_mem_req_t      MEM_REQ,   // pixel memory request
	input  wire bce_pkg::bce_mem_rsp_t MEM_RSP,   // memory ack and read data
	input  wire logic                  PSEL,      // apb select
	input  wire logic                  PENABLE,   // apb access phase
	input  wire logic                  PWRITE,    // apb direction
	input  wire logic [11:0]           PADDR,     // apb byte address
	input  wire logic [31:0]           PWDATA,    // apb write data
	output logic [31:0]                PRDATA,    // apb read data
	output logic                       PREADY,    // apb ready
	output logic                       PSLVERR,   // apb unmapped address
	output logic                       BUSY       // packet in progress
);
	// ============================================================
	// state and helper nets
	bce_pkg::bce_st_t   r, n;        // state and its next value
	logic [31:0]        hdr;         // current packet header
	logic [7:0]         explen;      // length expected for opcode
	logic               known;       // opcode is handled
	logic               pkt_ok;      // client, opcode and length agree
	logic [31:0]        rop_out;     // raster operation result
	logic [31:0]        daddr;       // destination pixel byte address
	logic [31:0]        saddr;       // source pixel byte address
	logic [31:0]        paddr_pat;   // colour pattern pixel address
	logic signed [31:0] dprod, sprod; // y times pitch
	logic signed [16:0] sx, sy;      // source coordinates of pixel
	logic [2:0]         prow, pcol;  // pattern row and column
	logic               pbit;        // mono pattern bit
	logic [31:0]        a, rd, sv;   // access address, aligned read, status view
	logic [3:0]         be;          // pixel byte enables
	logic [3:0]         cidx;        // context slot on apb
	logic signed [16:0] dx1, dx2, dy1, dy2, cl, cr, ct, cb; // clip work
	logic               clip_rej;    // trivial reject in clip stage
	logic [1:0]         dsh;         // shift from a depth field
	logic [63:0]        mono_pat;    // mono pattern, high dword above low dword

	// local names of the sequencer states, so the logic below reads plainly
	localparam bce_pkg::bce_state_t S_IDLE = bce_pkg::S_IDLE;
	localparam bce_pkg::bce_state_t S_DEC  = bce_pkg::S_DEC;
	localparam bce_pkg::bce_state_t S_CLIP = bce_pkg::S_CLIP;
	localparam bce_pkg::bce_state_t S_PIX  = bce_pkg::S_PIX;
	localparam bce_pkg::bce_state_t S_RDP  = bce_pkg::S_RDP;
	localparam bce_pkg::bce_state_t S_RDS  = bce_pkg::S_RDS;
	localparam bce_pkg::bce_state_t S_RDD  = bce_pkg::S_RDD;
	localparam bce_pkg::bce_state_t S_WR   = bce_pkg::S_WR;
	localparam bce_pkg::bce_state_t S_STEP = bce_pkg::S_STEP;

	assign hdr = r.pkt[0];
	assign CMD_READY = r.rdy;
	assign MEM_REQ = r.mem;
	assign PRDATA = r.apb.prdata;
	assign PREADY = r.apb.pready;
	assign PSLVERR = r.apb.pslverr;
	assign BUSY = r.busy;

	// ============================================================
	// address arithmetic, shared by the fill, copy, pixel and scan line commands
	assign sx = r.x + r.ox;
	assign sy = r.y + r.oy;
	assign dprod = 32'(r.y) * 32'(r.dpitch);
	assign sprod = 32'(sy) * 32'(r.spitch);
	assign daddr = r.dbase + 32'(dprod) + (32'(r.x) << r.shift);
	assign saddr = r.sbase + 32'(sprod) + (32'(sx) << r.shift);
	assign prow = 3'(r.y) + r.vs;
	assign pcol = 3'(r.x) + r.hs;
	assign paddr_pat = r.ctx[`BCE_C_PAT] + ((32'(prow) << r.shift) << `BCE_PAT_ROW_SH)
		+ (32'(pcol) << r.shift);
	assign mono_pat = {r.ctx[`BCE_C_MHI], r.ctx[`BCE_C_MLO]};
	assign pbit = mono_pat[{prow, pcol}];

	// one mux per bit: index is {pattern, source, destination}
	for (genvar i = 0; i < 32; i++) begin : g_rop
		assign rop_out[i] = r.raster_operation[{r.pat[i], r.src[i], r.dst[i]}];
	end

	// ============================================================
	// opcode table: which length each packet must carry
	always_comb begin
		known = 1'b1;
		explen = `BCE_LEN_PIXEL;
		case (hdr[`BCE_F_OP])
			`BCE_OP_SETUP:  explen = `BCE_LEN_SETUP;
			`BCE_OP_MSETUP: explen = `BCE_LEN_MSETUP;
			`BCE_OP_CLIP:   explen = `BCE_LEN_CLIP;
			`BCE_OP_FILL:   explen = `BCE_LEN_FILL;
			`BCE_OP_LCOPY:  explen = `BCE_LEN_LCOPY;
			`BCE_OP_PIXEL:  explen = `BCE_LEN_PIXEL;
			`BCE_OP_SCAN:   explen = `BCE_LEN_SCAN;
			`BCE_OP_XYCOPY: explen = `BCE_LEN_XYCOPY;
			default:        known = 1'b0;
		endcase
		pkt_ok = known && hdr[`BCE_F_CLIENT] == `BCE_CLIENT_2D && hdr[`BCE_F_LEN] == explen;
	end

	// ============================================================
	// next-state logic
	always_comb begin
		n = r;
		rd = '0;
		a = daddr;
		sv = '0;
		cidx = '0;
		be = '0;
		dsh = `BCE_SH_16;
		clip_rej = 1'b0;
		dx1 = r.xs;
		dx2 = r.xe;
		dy1 = r.ys;
		dy2 = r.ye;
		cl = 17'(r.ctx[`BCE_C_CTL][`BCE_F_CLIPV]);
		ct = 17'(r.ctx[`BCE_C_CTL][`BCE_F_HI] & 16'h7fff);
		cr = 17'(r.ctx[`BCE_C_CBR][`BCE_F_CLIPV]);
		cb = 17'(r.ctx[`BCE_C_CBR][`BCE_F_HI] & 16'h7fff);
		// depth code of the control word in use at decode
		case (r.pkt[1][`BCE_F_DEPTH])
			`BCE_DEPTH_8:  dsh = `BCE_SH_8;
			`BCE_DEPTH_32: dsh = `BCE_SH_32;
			default:       dsh = `BCE_SH_16;
		endcase
		if (r.st == S_PIX || r.st == S_RDP) begin
			a = paddr_pat;
		end else if (r.st == S_RDS) begin
			a = saddr;
		end
		// byte lanes of one naturally aligned pixel
		case (r.shift)
			`BCE_SH_8:  be = 4'h1 << a[1:0];
			`BCE_SH_16: be = 4'h3 << a[1:0];
			default:    be = {r.alpha, r.rgb, r.rgb, r.rgb};
		endcase
		// ---- apb slave, one wait state; engine updates below win over clears
		n.apb.pready = 1'b0;
		n.apb.pslverr = 1'b0;
		if (PSEL && PENABLE && !r.apb.pready) begin
			n.apb.pready = 1'b1;
			sv[`BCE_S_BAD] = r.bad;
			sv[`BCE_S_BUSY] = r.busy;
			sv[31:16] = r.rej;
			if (PADDR == `BCE_A_CTRL) begin
				rd = 32'(r.en);
				if (PWRITE) begin
					n.en = PWDATA[0];
				end
			end else if (PADDR == `BCE_A_STAT) begin
				rd = sv;
				if (PWRITE && PWDATA[`BCE_S_BAD]) begin
					n.bad = 1'b0;
				end
				if (PWRITE && PWDATA[`BCE_S_RCLR]) begin
					n.rej = '0;
				end
			end else if (PADDR >= `BCE_A_CTX0 && PADDR <= `BCE_A_CTXN && PADDR[1:0] == 2'h0) begin
				cidx = 4'((PADDR - `BCE_A_CTX0) >> 2);
				rd = r.ctx[cidx];
				// restore only between packets so a packet never sees a mix
				if (PWRITE && r.st == S_IDLE && r.cnt == '0) begin
					n.ctx[cidx] = PWDATA;
				end
			end else begin
				n.apb.pslverr = 1'b1;
			end
			n.apb.prdata = PWRITE ? r.apb.prdata : rd;
		end
		rd = '0;
		// ---- engine sequencer
		case (r.st)
			S_IDLE: begin
				// gather one packet, strictly one after another
				if (CMD_IN.valid && r.rdy) begin
					if (r.cnt < `BCE_PKT_MAX) begin
						n.pkt[4'(r.cnt)] = CMD_IN.data;
					end
					if (r.cnt == '0) begin
						n.tot = 9'(CMD_IN.data[`BCE_F_LEN]) + `BCE_LEN_BIAS;
					end
					n.cnt = r.cnt + 9'h001;
					if (n.cnt == n.tot) begin
						n.cnt = '0;
						n.st = S_DEC;
					end
				end
			end
			S_DEC: begin
				n.st = S_IDLE;
				n.op = hdr[`BCE_F_OP];
				n.xy = 1'b0;
				n.scan = 1'b0;
				n.ox = '0;
				n.oy = '0;
				n.xback = 1'b0;
				n.yback = 1'b0;
				n.use_src = 1'b0;
				n.raster_operation = r.pkt[1][`BCE_F_ROP];
				n.shift = dsh;
				n.dpitch = r.pkt[1][`BCE_F_LO];
				n.alpha = hdr[`BCE_B_ALPHA];
				n.rgb = hdr[`BCE_B_RGB];
				n.clip = r.ctx[`BCE_C_CTRL][`BCE_B_CLIP];
				n.xs = 17'(signed'(r.pkt[1][`BCE_F_LO]));
				n.ys = 17'(signed'(r.pkt[1][`BCE_F_HI]));
				n.xe = 17'(signed'(r.pkt[2][`BCE_F_LO]));
				n.ye = 17'(signed'(r.pkt[2][`BCE_F_HI]));
				if (!pkt_ok) begin
					n.bad = 1'b1; // wrong client, opcode or length: packet dropped
				end else begin
					case (hdr[`BCE_F_OP])
						`BCE_OP_SETUP, `BCE_OP_MSETUP: begin
							// shared state for the coordinate commands
							n.ctx[`BCE_C_CTRL] = r.pkt[1];
							n.ctx[`BCE_C_CTL] = r.pkt[2];
							n.ctx[`BCE_C_CBR] = r.pkt[3];
							n.ctx[`BCE_C_DBASE] = r.pkt[4];
							n.ctx[`BCE_C_BG] = r.pkt[5];
							n.ctx[`BCE_C_FG] = r.pkt[6];
							n.ctx[`BCE_C_EXT][`BCE_X_ALPHA] = hdr[`BCE_B_ALPHA];
							n.ctx[`BCE_C_EXT][`BCE_X_RGB] = hdr[`BCE_B_RGB];
							n.ctx[`BCE_C_EXT][`BCE_X_MONO] = hdr[`BCE_F_OP] == `BCE_OP_MSETUP;
							if (hdr[`BCE_F_OP] == `BCE_OP_MSETUP) begin
								n.ctx[`BCE_C_MLO] = r.pkt[7];
								n.ctx[`BCE_C_MHI] = r.pkt[8];
							end else begin
								n.ctx[`BCE_C_PAT] = r.pkt[7];
							end
						end
						`BCE_OP_CLIP: begin
							n.ctx[`BCE_C_CTL] = r.pkt[1];
							n.ctx[`BCE_C_CBR] = r.pkt[2];
						end
						`BCE_OP_FILL, `BCE_OP_LCOPY: begin
							// linear surface: origin 0, width bytes to pixels, no clip
							n.clip = 1'b0;
							n.xs = '0;
							n.ys = '0;
							n.xe = 17'(r.pkt[2][`BCE_F_LO] >> dsh);
							n.ye = 17'(r.pkt[2][`BCE_F_HI]);
							n.dbase = r.pkt[3];
							n.pat = r.pkt[4];
							n.sbase = r.pkt[5];
							n.spitch = r.pkt[4][`BCE_F_LO];
							n.use_src = hdr[`BCE_F_OP] == `BCE_OP_LCOPY;
							n.xback = n.use_src && r.pkt[1][`BCE_B_DIR];
							n.st = S_CLIP;
						end
						`BCE_OP_XYCOPY: begin
							n.xy = 1'b1;
							n.use_src = 1'b1;
							n.xs = 17'(signed'(r.pkt[2][`BCE_F_LO]));
							n.ys = 17'(signed'(r.pkt[2][`BCE_F_HI]));
							n.xe = 17'(signed'(r.pkt[3][`BCE_F_LO]));
							n.ye = 17'(signed'(r.pkt[3][`BCE_F_HI]));
							n.dbase = r.pkt[4];
							n.ox = 17'(signed'(r.pkt[5][`BCE_F_LO]));
							n.oy = 17'(signed'(r.pkt[5][`BCE_F_HI]));
							n.spitch = r.pkt[6][`BCE_F_LO];
							n.sbase = r.pkt[7];
							n.st = S_CLIP;
						end
						default: begin
							// pixel and scan line take their setup from shared state
							n.raster_operation = r.ctx[`BCE_C_CTRL][`BCE_F_ROP];
							n.dpitch = r.ctx[`BCE_C_CTRL][`BCE_F_LO];
							n.dbase = r.ctx[`BCE_C_DBASE];
							n.alpha = r.ctx[`BCE_C_EXT][`BCE_X_ALPHA];
							n.rgb = r.ctx[`BCE_C_EXT][`BCE_X_RGB];
							n.pat = r.ctx[`BCE_C_FG];
							n.shift = `BCE_SH_16;
							if (r.ctx[`BCE_C_CTRL][`BCE_F_DEPTH] == `BCE_DEPTH_8) begin
								n.shift = `BCE_SH_8;
							end else if (r.ctx[`BCE_C_CTRL][`BCE_F_DEPTH] == `BCE_DEPTH_32) begin
								n.shift = `BCE_SH_32;
							end
							n.scan = hdr[`BCE_F_OP] == `BCE_OP_SCAN;
							n.solid = r.ctx[`BCE_C_CTRL][`BCE_B_SOLID];
							n.transp = r.ctx[`BCE_C_CTRL][`BCE_B_MTRANSP];
							n.hs = hdr[`BCE_F_HSEED];
							n.vs = hdr[`BCE_F_VSEED];
							if (!n.scan) begin
								n.xe = n.xs + 17'sh00001;
								n.ye = n.ys + 17'sh00001;
							end
							n.st = S_CLIP;
						end
					endcase
					// skip the destination read when the result ignores it
					n.use_dst = ((n.raster_operation ^ (n.raster_operation >> 1)) & `BCE_ROP_DMASK) != 8'h00;
				end
			end
			S_CLIP: begin
				// negative source start moves the destination start
				if (r.xy && r.ox < 0) begin
					dx1 = r.xs - r.ox;
				end
				if (r.xy && r.oy < 0) begin
					dy1 = r.ys - r.oy;
				end
				n.ox = r.ox - r.xs;
				n.oy = r.oy - r.ys;
				if (r.clip) begin
					// top-left inclusive, bottom-right exclusive
					dx1 = (dx1 < cl) ? cl : dx1;
					dy1 = (dy1 < ct) ? ct : dy1;
					dx2 = (dx2 > cr) ? cr : dx2;
					dy2 = (dy2 > cb) ? cb : dy2;
				end
				clip_rej = dx2 <= dx1 || dy2 <= dy1;
				// same surface: walk away from the overlap, no overlap test
				n.xback = r.xback || (r.xy && r.sbase == r.dbase && n.ox < 0);
				n.yback = r.xy && r.sbase == r.dbase && n.oy < 0;
				n.xs = dx1;
				n.xe = dx2;
				n.ys = dy1;
				n.ye = dy2;
				n.x = n.xback ? dx2 - 17'sh00001 : dx1;
				n.y = n.yback ? dy2 - 17'sh00001 : dy1;
				if (clip_rej) begin
					n.rej = n.rej + 16'h0001;
					n.st = S_IDLE;
				end else begin
					n.st = S_PIX;
				end
			end
			S_PIX: begin
				n.st = n.use_src ? S_RDS : (n.use_dst ? S_RDD : S_WR);
				if (r.scan && !r.ctx[`BCE_C_EXT][`BCE_X_MONO] && !r.solid) begin
					n.st = S_RDP; // colour pattern comes through the texture cache
				end else if (r.scan) begin
					n.pat = (pbit || r.solid) ? r.ctx[`BCE_C_FG] : r.ctx[`BCE_C_BG];
					if (!pbit && !r.solid && r.transp) begin
						n.st = S_STEP; // transparent pattern bit: leave pixel alone
					end
				end
			end
			S_RDP, S_RDS, S_RDD: begin
				if (!r.mem.valid) begin
					n.mem.valid = 1'b1;
					n.mem.write = 1'b0;
					n.mem.tex = r.st == S_RDP;
					n.mem.addr = {a[31:2], 2'h0};
					n.mem.be = 4'hf;
				end else if (MEM_RSP.ack) begin
					n.mem.valid = 1'b0;
					rd = MEM_RSP.data >> {a[1:0], 3'h0};
					if (r.st == S_RDP) begin
						n.pat = rd;
						n.st = r.use_dst ? S_RDD : S_WR;
					end else if (r.st == S_RDS) begin
						n.src = rd;
						n.st = r.use_dst ? S_RDD : S_WR;
					end else begin
						n.dst = rd;
						n.st = S_WR;
					end
				end
			end
			S_WR: begin
				if (!r.mem.valid) begin
					n.mem.valid = 1'b1;
					n.mem.write = 1'b1;
					n.mem.tex = 1'b0;
					n.mem.addr = {daddr[31:2], 2'h0};
					n.mem.wdata = rop_out << {daddr[1:0], 3'h0};
					n.mem.be = be;
				end else if (MEM_RSP.ack) begin
					n.mem.valid = 1'b0;
					n.st = S_STEP;
				end
			end
			S_STEP: begin
				// advance along the line, then to the next line
				n.st = S_PIX;
				if (r.x != (r.xback ? r.xs : r.xe - 17'sh00001)) begin
					n.x = r.xback ? r.x - 17'sh00001 : r.x + 17'sh00001;
				end else begin
					n.x = r.xback ? r.xe - 17'sh00001 : r.xs;
					if (r.y != (r.yback ? r.ys : r.ye - 17'sh00001)) begin
						n.y = r.yback ? r.y - 17'sh00001 : r.y + 17'sh00001;
					end else begin
						n.st = S_IDLE; // last write acknowledged before the next packet
					end
				end
			end
			default: n.st = S_IDLE;
		endcase
		n.busy = n.st != S_IDLE || n.cnt != '0;
		n.rdy = n.st == S_IDLE && n.en;
	end

	// ============================================================
	// state register
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			r <= '0;
			r.st <= bce_pkg::S_IDLE;
			r.en <= `BCE_RST_EN;
		end else begin
			r <= n;
		end
	end

	// ============================================================
	// checks
	default clocking cb_chk @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	sequence seq_fill_dec;
		r.st == S_DEC && pkt_ok && hdr[`BCE_F_OP] == `BCE_OP_FILL;
	endsequence
	sequence seq_clip_then_run;
		r.st == S_CLIP ##1 (r.st == S_PIX || r.st == S_IDLE);
	endsequence

	chk_fill_decode: assert property (seq_fill_dec |=> seq_clip_then_run)
		else $error("fill packet not sent to clip stage");
	chk_lin_noclip: assert property (seq_fill_dec |=> !r.clip)
		else $error("linear fill clipped");
	chk_setup_load: assert property (r.st == S_DEC && pkt_ok && hdr[`BCE_F_OP] == `BCE_OP_SETUP
		|=> r.ctx[`BCE_C_FG] == $past(r.pkt[6]) && r.ctx[`BCE_C_CTL] == $past(r.pkt[2]))
		else $error("setup state not loaded");
	chk_ctx_hold: assert property (r.st != S_DEC && !(PSEL && PENABLE && PWRITE)
		|=> $stable(r.ctx))
		else $error("context changed without setup or restore");
	chk_tex_route: assert property (r.mem.valid |-> r.mem.tex == (r.st == S_RDP))
		else $error("wrong cache selected");
	chk_be_mask: assert property (r.mem.valid && r.mem.write && r.shift == `BCE_SH_32
		|-> r.mem.be == {r.alpha, r.rgb, r.rgb, r.rgb})
		else $error("32-bit byte mask wrong");
	chk_be_align: assert property (r.mem.valid && r.mem.write && r.shift == `BCE_SH_16
		|-> r.mem.be == 4'h3 || r.mem.be == 4'hc)
		else $error("16-bit pixel not aligned");
	chk_lcopy_dir: assert property (r.st == S_DEC && pkt_ok && hdr[`BCE_F_OP] == `BCE_OP_LCOPY
		|=> r.xback == $past(r.pkt[1][`BCE_B_DIR]))
		else $error("copy direction not taken");
	chk_reject_quiet: assert property (r.st == S_CLIP && clip_rej
		|=> r.st == S_IDLE && !r.mem.valid && r.rej == $past(r.rej) + 16'h0001)
		else $error("reject did not stop the packet");
	chk_xy_back: assert property (r.st == S_CLIP && r.xy && r.sbase == r.dbase
		&& r.ox < r.xs |=> r.xback)
		else $error("same-surface copy not walked right to left");
	chk_yy_back: assert property (r.st == S_CLIP && r.xy && r.sbase == r.dbase
		&& r.oy < r.ys |=> r.yback)
		else $error("same-surface copy not walked bottom up");
	chk_in_order: assert property (r.rdy |-> r.st == S_IDLE)
		else $error("dword taken while a packet runs");
endmodule : bce_engine

/* File: verification/bce_mem_model.sv */
// bce_mem_model.sv: graphics memory seen through the caches
`timescale 1ns/1ps
module bce_mem_model (
	input  wire logic                  CLK,     // core clock
	input  wire logic                  SYS_RST, // sync reset
	input  wire logic [1:0]            LAT,     // wait cycles before ack
	input  wire bce_pkg::bce_mem_req_t REQ,     // engine request
	output bce_pkg::bce_mem_rsp_t      RSP      // ack and read data
);
	bce_pkg::bce_mem_req_t wr_r;   // last write taken
	int                    nwr_r;  // writes taken
	logic [1:0]            wait_r; // cycles waited
	// ============================================================
	// answer after LAT waits; idle data toggles so stale data never matches
	always @(posedge CLK) begin
		RSP.data <= SYS_RST ? 32'h0 : ~RSP.data;
		if (SYS_RST) begin
			RSP.ack <= 1'b0;
			wait_r <= 2'h0;
			nwr_r <= 0;
		end else if (RSP.ack) begin
			RSP.ack <= 1'b0;
			wait_r <= 2'h0;
		end else if (REQ.valid && wait_r >= LAT) begin
			RSP.ack <= 1'b1;
			RSP.data <= REQ.addr ^ 32'h5a5a0000;
			if (REQ.write) begin
				wr_r <= REQ;
				nwr_r <= nwr_r + 1;
			end
		end else if (REQ.valid) begin
			wait_r <= wait_r + 2'h1;
		end
	end
endmodule : bce_mem_model

/* File: verification/tb.sv */
// tb.sv: self-checking bench of the blit command engine
`timescale 1ns/1ps
module tb;
	logic                  clk = 1'b0; // core clock
	logic                  rst = 1'b1; // sync reset
	bce_pkg::bce_cmd_t     cmd = '0;   // command stream
	bce_pkg::bce_mem_req_t req;        // memory request
	bce_pkg::bce_mem_rsp_t rsp;        // memory answer
	logic                  psel = 1'b0, pen = 1'b0, pwr = 1'b0; // apb controls
	logic [11:0]           pa = 12'h0; // apb address
	logic [31:0]           pwd = 32'h0, prd, rd; // apb data
	logic                  rdy, prdy, perr, busy, err; // handshakes
	logic [1:0]            lat = 2'h0; // memory wait cycles
	int                    num_errors = 0, n_tests = 0, cyc = 0;
	bce_engine u_dut (.CLK(clk), .SYS_RST(rst), .CMD_IN(cmd), .CMD_READY(rdy),
		.MEM_REQ(req), .MEM_RSP(rsp), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
		.BUSY(busy));
	bce_mem_model u_mem (.CLK(clk), .SYS_RST(rst), .LAT(lat), .REQ(req), .RSP(rsp));
	initial forever #20 clk = ~clk;
	// ============================================================
	// shared tasks
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic results;
		$display("errors %0d tests %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : results
	// apb transfer; ready, read data and error taken at one rising edge
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (prdy !== 1'b1);
		rd = prd;
		err = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic send(logic [31:0] d);
		logic r;
		cmd <= {1'b1, d};
		do begin
			@(negedge clk);
			r = rdy;
			@(posedge clk);
		end while (r !== 1'b1);
	endtask : send
	task automatic idle;
		cmd <= '0;
		do @(negedge clk); while (busy !== 1'b0);
		@(posedge clk);
	endtask : idle
	// ============================================================
	// scenarios
	task automatic t_regs;
		apb(1'b0, 12'h000, 32'h0);
		chk("ctrl", rd, 32'h1);
		apb(1'b0, 12'h008, 32'h0);
		chk("unmapped", {31'h0, err}, 32'h1);
		apb(1'b0, 12'h010, 32'h0);
		chk("ctx0", rd, 32'h0);
		apb(1'b1, 12'h014, 32'h12345678);
		apb(1'b0, 12'h014, 32'h0);
		chk("ctx1", rd, 32'h12345678);
		apb(1'b1, 12'h000, 32'h0);
		chk("ready off", {31'h0, rdy}, 32'h0);
		apb(1'b1, 12'h000, 32'h1);
	endtask : t_regs
	task automatic t_fill(logic [31:0] h, logic [31:0] c1, logic [31:0] a, logic [3:0] be);
		int n;
		logic [31:0] m;
		n = u_mem.nwr_r;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		send(h);
		send(c1);
		send({16'h1, (c1[25:24] == 2'h3) ? 16'h4 : 16'h1});
		send(a); // one render-cache destination, no source operand
		send(32'h11223344);
		chk("busy", {31'h0, busy}, 32'h1);
		idle();
		chk("writes", 32'(u_mem.nwr_r - n), 32'h1);
		chk("addr", u_mem.wr_r.addr, {a[31:2], 2'h0});
		chk("be", {28'h0, u_mem.wr_r.be}, {28'h0, be});
		chk("data", u_mem.wr_r.wdata & m, (32'h11223344 << (8 * a[1:0])) & m);
		chk("cache", {31'h0, u_mem.wr_r.tex}, 32'h0);
	endtask : t_fill
	task automatic t_bad;
		int n;
		n = u_mem.nwr_r;
		send(32'h70000003);
		repeat (4) send(32'h0);
		idle();
		chk("dropped", 32'(u_mem.nwr_r - n), 32'h0);
		apb(1'b0, 12'h004, 32'h0);
		chk("bad flag", rd & 32'h1, 32'h1);
		apb(1'b1, 12'h004, 32'h1);
		apb(1'b0, 12'h004, 32'h0);
		chk("bad clear", rd & 32'h1, 32'h0);
	endtask : t_bad
	// setup with clip 2..8, 8-bit, fg a5h; pixel on the inclusive corner, one on the right edge
	task automatic t_xy;
		int n;
		n = u_mem.nwr_r;
		send(32'h40500006);
		send(32'h40f00100);
		send(32'h00020002);
		send(32'h00080008);
		send(32'h00003000);
		send(32'h0);
		send(32'h000000a5);
		send(32'h0);
		send(32'h49000000);
		send(32'h00020002);
		idle();
		chk("px addr", u_mem.wr_r.addr, 32'h00003200);
		chk("px be", {28'h0, u_mem.wr_r.be}, 32'h4);
		chk("px data", u_mem.wr_r.wdata & 32'h00ff0000, 32'h00a50000);
		send(32'h49000000);
		send(32'h00040008);
		idle();
		chk("px writes", 32'(u_mem.nwr_r - n), 32'h1);
		apb(1'b0, 12'h004, 32'h0);
		chk("rejects", rd >> 16, 32'h1);
		apb(1'b0, 12'h02c, 32'h0);
		chk("clip ctx", rd, 32'h00020002);
	endtask : t_xy
	// ============================================================
	// main sequence and hang guard
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		lat <= 2'h3;
		t_fill(32'h50100003, 32'h03f00100, 32'h00002000, 4'h7);
		lat <= 2'h0;
		t_fill(32'h50000003, 32'h00f00100, 32'h00001003, 4'h8);
		t_bad();
		// no cacheable pair no overlapping linear copy no mono source
		t_xy();
		results();
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			results();
		end
	end
endmodule : tb
